// ===== logic/sync_serial_ctrl_rx_clocking.sv
// control, bit-rate divider and receive clock logic of the serial controller
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sync_serial_regs.svh"
module sync_serial_ctrl_rx_clocking (
  input  wire logic                    aclk,             // master clock
  input  wire logic                    aresetn,          // sync reset, low
  input  wire logic [7:0]              s_axi_awaddr,     // write address
  input  wire logic                    s_axi_awvalid,    // write address valid
  output logic                         s_axi_awready,    // write address ready
  input  wire logic [31:0]             s_axi_wdata,      // write data
  input  wire logic [3:0]              s_axi_wstrb,      // byte enables
  input  wire logic                    s_axi_wvalid,     // write data valid
  output logic                         s_axi_wready,     // write data ready
  output sync_serial_pkg::axi_resp_t   s_axi_bresp,      // write response
  output logic                         s_axi_bvalid,     // write response valid
  input  wire logic                    s_axi_bready,     // write response ready
  input  wire logic [7:0]              s_axi_araddr,     // read address
  input  wire logic                    s_axi_arvalid,    // read address valid
  output logic                         s_axi_arready,    // read address ready
  output logic [31:0]                  s_axi_rdata,      // read data
  output sync_serial_pkg::axi_resp_t   s_axi_rresp,      // read response
  output logic                         s_axi_rvalid,     // read data valid
  input  wire logic                    s_axi_rready,     // read data ready
  input  wire logic                    tx_clock_in,      // transmit clock level
  input  wire logic                    rx_clock_in,      // receive clock pin level
  output logic                         rx_clock_out,     // receive clock pin drive
  output logic                         rx_clock_oe,      // receive clock pin enable
  input  wire logic                    rx_frame_sync_in, // frame sync pin level
  input  wire logic                    tx_start_evt,     // transmitter start pulse
  input  wire logic                    tx_word_busy,     // transmitter mid-word
  input  wire logic                    cmp0_match,       // compare 0 hit pulse
  input  wire logic                    cmp1_match,       // compare 1 hit pulse
  input  wire logic                    rx_word_end,      // last bit of word taken
  output logic                         div_clock,        // divided clock
  output logic                         rx_sample_tick,   // sampling edge pulse
  output logic                         rx_fs_drive_tick, // sync drive edge pulse
  output logic                         rx_first_bit,     // first bit edge pulse
  output logic                         rx_busy,          // word in reception
  output logic                         rx_period_tick,   // period sync pulse
  output logic                         rx_enabled,       // receiver enabled
  output logic                         tx_enabled,       // transmitter enabled
  output logic                         soft_reset_pulse  // software reset pulse
);
  import sync_serial_pkg::*;

  logic        aw_hold_reg, aw_hold_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  axi_resp_t   bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  axi_resp_t   rresp_reg, rresp_next;
  logic [31:0] rate_reg, rate_next;
  logic [31:0] rxclk_reg, rxclk_next;
  logic        wr_do;
  logic [7:0]  wr_addr;
  logic [31:0] wmask;
  logic [31:0] cmd;
  logic        sw;
  logic        rx_en_reg, rx_en_next, rx_offp_reg, rx_offp_next;
  logic        tx_en_reg, tx_en_next, tx_offp_reg, tx_offp_next;
  logic        cont_reg, cont_next, fs_prev_reg, fs_prev_next;

  // write, response and read channels
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_do   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_addr = {aw_addr_reg[7:2], 2'b00};
  assign cmd     = (wr_do && wr_addr == `OFS_CMD) ? (w_data_reg & wmask) : 32'h0000_0000;
  assign sw      = cmd[`CMD_SOFT_RESET_CMD];

  // byte lanes to a bit mask
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{w_strb_reg[i]}};
  end

  // bus next state
  always_comb begin
    logic [7:0] ra;
    ra           = {s_axi_araddr[7:2], 2'b00};
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wr_addr == `OFS_CMD || wr_addr == `OFS_RATE ||
                      wr_addr == `OFS_RXCLK) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (ra)
        `OFS_CMD:   rdata_next = 32'h0000_0000; // write-only
        `OFS_RATE:  rdata_next = rate_reg;
        `OFS_RXCLK: rdata_next = rxclk_reg;
        `OFS_STAT:  rdata_next = {28'h000_0000, cont_reg, rx_busy, tx_en_reg, rx_en_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // configuration next state, soft reset restores defaults
  always_comb begin
    rate_next  = rate_reg;
    rxclk_next = rxclk_reg;
    if (sw) begin
      rate_next  = `RATE_RST;
      rxclk_next = `RXCLK_RST;
    end else if (wr_do && wr_addr == `OFS_RATE) begin
      rate_next = (rate_reg & ~wmask) | (w_data_reg & wmask & `RATE_WMASK);
    end else if (wr_do && wr_addr == `OFS_RXCLK) begin
      rxclk_next = (rxclk_reg & ~wmask) | (w_data_reg & wmask & `RXCLK_WMASK);
    end
  end

  // bus and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
      rate_reg    <= `RATE_RST;
      rxclk_reg   <= `RXCLK_RST;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      rate_reg    <= rate_next;
      rxclk_reg   <= rxclk_next;
    end
  end

  logic [11:0] div_n;
  logic [11:0] div_cnt_reg, div_cnt_next;
  logic        div_clk_reg, div_clk_next;
  assign div_n     = rate_reg[`DIV_F];
  assign div_clock = div_clk_reg;

  // divider: toggles every N cycles, period 2N
  always_comb begin
    div_cnt_next = 12'h000;
    div_clk_next = 1'b0;
    if (div_n != 12'h000) begin
      if (div_cnt_reg >= div_n - 12'h001) begin
        div_clk_next = !div_clk_reg;
      end else begin
        div_cnt_next = div_cnt_reg + 12'h001;
        div_clk_next = div_clk_reg;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= 12'h000;
      div_clk_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      div_clk_reg <= div_clk_next;
    end
  end

  logic sel_lvl, gate_ok, clk_lvl, samp, drv, drive_oe;
  logic clk_prev_reg, pin_out_reg, pin_oe_reg, samp_reg, drv_reg;

  // clock source, gating and pin drive choice
  always_comb begin
    case (rxclk_reg[`SRC_F])
      `SRC_DIV: sel_lvl = div_clk_reg;
      `SRC_TX:  sel_lvl = tx_clock_in;
      `SRC_PIN: sel_lvl = rx_clock_in;
      default:  sel_lvl = 1'b0;
    endcase
    case (rxclk_reg[`GATE_F])
      `GATE_NONE: gate_ok = 1'b1;
      `GATE_LOW:  gate_ok = !rx_frame_sync_in;
      `GATE_HIGH: gate_ok = rx_frame_sync_in;
      default:    gate_ok = 1'b0;
    endcase
    case (rxclk_reg[`DRV_F])
      `DRV_CONT: drive_oe = 1'b1;
      `DRV_XFER: drive_oe = rx_busy;
      default:   drive_oe = 1'b0;
    endcase
  end

  assign clk_lvl = sel_lvl && gate_ok;
  // polarity only picks the edge; the pin keeps the true level
  assign samp = rxclk_reg[`POL_B] ? (clk_lvl && !clk_prev_reg)
                                   : (!clk_lvl && clk_prev_reg);
  assign drv  = rxclk_reg[`POL_B] ? (!clk_lvl && clk_prev_reg)
                                   : (clk_lvl && !clk_prev_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_reg <= 1'b0;
      pin_out_reg  <= 1'b0;
      pin_oe_reg   <= 1'b0;
      samp_reg     <= 1'b0;
      drv_reg      <= 1'b0;
    end else begin
      clk_prev_reg <= clk_lvl;
      pin_out_reg  <= clk_lvl;
      pin_oe_reg   <= drive_oe;
      samp_reg     <= samp;
      drv_reg      <= drv;
    end
  end

  assign rx_clock_out     = pin_out_reg;
  assign rx_clock_oe      = pin_oe_reg;
  assign rx_sample_tick   = samp_reg;
  assign rx_fs_drive_tick = drv_reg;

  rx_state_t   state_reg, state_next;
  logic [7:0]  lag_cnt_reg, lag_cnt_next;
  logic [8:0]  per_cnt_reg, per_cnt_next;
  logic        cmp0p_reg, cmp0p_next, txp_reg, txp_next;
  logic        first_reg, first_next, per_reg, per_next, sw_reg;
  logic        hit, start_evt;
  logic [3:0]  st_code;
  logic [7:0]  lag;
  assign st_code = rxclk_reg[`START_F];
  assign lag     = rxclk_reg[`LAG_F];

  // start event decode at the sampling edge
  always_comb begin
    case (st_code)
      `ST_CONT: hit = 1'b1;
      `ST_TX:   hit = txp_reg;
      `ST_LOW:  hit = !rx_frame_sync_in;
      `ST_HIGH: hit = rx_frame_sync_in;
      `ST_FALL: hit = fs_prev_reg && !rx_frame_sync_in;
      `ST_RISE: hit = !fs_prev_reg && rx_frame_sync_in;
      `ST_CHG,
      `ST_EDGE: hit = fs_prev_reg != rx_frame_sync_in;
      `ST_CMP0: hit = cmp0p_reg;
      default:  hit = 1'b0;
    endcase
  end

  assign start_evt = samp && rx_en_reg && state_reg == RX_IDLE && (hit || cont_reg);

  // receiver, transmitter enables and reception sequence
  always_comb begin
    state_next   = state_reg;
    lag_cnt_next = lag_cnt_reg;
    rx_en_next   = rx_en_reg;
    rx_offp_next = rx_offp_reg;
    tx_en_next   = tx_en_reg;
    tx_offp_next = tx_offp_reg;
    cmp0p_next   = cmp0p_reg || cmp0_match;
    txp_next     = txp_reg || tx_start_evt;
    cont_next    = cont_reg;
    fs_prev_next = samp ? rx_frame_sync_in : fs_prev_reg;
    first_next   = 1'b0;
    per_next     = 1'b0;
    per_cnt_next = per_cnt_reg;
    if (rxclk_reg[`PER_F] == 8'h00) begin
      per_cnt_next = 9'h000;
    end else if (samp) begin
      if (per_cnt_reg >= {rxclk_reg[`PER_F], 1'b1}) begin
        per_cnt_next = 9'h000;
        per_next     = 1'b1;
      end else begin
        per_cnt_next = per_cnt_reg + 9'h001;
      end
    end
    if (cmp1_match) cont_next = 1'b0;
    case (state_reg)
      RX_IDLE: begin
        if (start_evt) begin
          if (st_code == `ST_CMP0 && !cmp0_match) cmp0p_next = 1'b0;
          if (st_code == `ST_TX && !tx_start_evt) txp_next = 1'b0;
          if (st_code == `ST_CMP0 && rxclk_reg[`STOP_B]) cont_next = 1'b1;
          if (lag == 8'h00) begin
            state_next = RX_RECV;
            first_next = 1'b1;
          end else begin
            state_next   = RX_LAG;
            lag_cnt_next = lag;
          end
        end
      end
      RX_LAG: begin
        if (!rx_en_reg) begin
          state_next = RX_IDLE;
        end else if (samp) begin
          if (lag_cnt_reg <= 8'h01) begin
            state_next = RX_RECV;
            first_next = 1'b1;
          end else begin
            lag_cnt_next = lag_cnt_reg - 8'h01;
          end
        end
      end
      RX_RECV: begin
        if (rx_word_end) begin
          state_next = RX_IDLE;
          if (rx_offp_reg) begin
            rx_en_next   = 1'b0;
            rx_offp_next = 1'b0;
          end
        end
      end
      default: state_next = RX_IDLE;
    endcase
    if (tx_offp_reg && !tx_word_busy) begin
      tx_en_next   = 1'b0;
      tx_offp_next = 1'b0;
    end
    if (cmd[`CMD_RX_OFF]) begin
      if (state_reg == RX_RECV && !rx_word_end) begin
        rx_offp_next = 1'b1;
      end else begin
        rx_en_next   = 1'b0;
        rx_offp_next = 1'b0;
      end
    end else if (cmd[`CMD_RX_ON]) begin
      rx_en_next   = 1'b1;
      rx_offp_next = 1'b0;
    end
    if (cmd[`CMD_TX_OFF]) begin
      if (tx_word_busy) begin
        tx_offp_next = 1'b1;
      end else begin
        tx_en_next   = 1'b0;
        tx_offp_next = 1'b0;
      end
    end else if (cmd[`CMD_TX_ON]) begin
      tx_en_next   = 1'b1;
      tx_offp_next = 1'b0;
    end
    if (!rx_en_next) cont_next = 1'b0;
    if (sw) begin
      state_next   = RX_IDLE;
      rx_en_next   = 1'b0;
      rx_offp_next = 1'b0;
      tx_en_next   = 1'b0;
      tx_offp_next = 1'b0;
      cmp0p_next   = 1'b0;
      txp_next     = 1'b0;
      cont_next    = 1'b0;
      first_next   = 1'b0;
      per_cnt_next = 9'h000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= RX_IDLE;
      lag_cnt_reg <= 8'h00;
      per_cnt_reg <= 9'h000;
      rx_en_reg   <= 1'b0;
      rx_offp_reg <= 1'b0;
      tx_en_reg   <= 1'b0;
      tx_offp_reg <= 1'b0;
      cmp0p_reg   <= 1'b0;
      txp_reg     <= 1'b0;
      cont_reg    <= 1'b0;
      fs_prev_reg <= 1'b0;
      first_reg   <= 1'b0;
      per_reg     <= 1'b0;
      sw_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      lag_cnt_reg <= lag_cnt_next;
      per_cnt_reg <= per_cnt_next;
      rx_en_reg   <= rx_en_next;
      rx_offp_reg <= rx_offp_next;
      tx_en_reg   <= tx_en_next;
      tx_offp_reg <= tx_offp_next;
      cmp0p_reg   <= cmp0p_next;
      txp_reg     <= txp_next;
      cont_reg    <= cont_next;
      fs_prev_reg <= fs_prev_next;
      first_reg   <= first_next;
      per_reg     <= per_next;
      sw_reg      <= sw;
    end
  end

  assign rx_busy          = state_reg == RX_RECV;
  assign rx_first_bit     = first_reg;
  assign rx_period_tick   = per_reg;
  assign rx_enabled       = rx_en_reg;
  assign tx_enabled       = tx_en_reg;
  assign soft_reset_pulse = sw_reg;

  // helper: cycles between divided clock toggles
  logic        dprev_reg, dseen_reg;
  logic [12:0] dgap_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || div_n != rate_next[`DIV_F]) begin
      dprev_reg <= 1'b0;
      dseen_reg <= 1'b0;
      dgap_reg  <= 13'h0000;
    end else begin
      dprev_reg <= div_clk_reg;
      dseen_reg <= dseen_reg || (div_clk_reg != dprev_reg);
      dgap_reg  <= (div_clk_reg != dprev_reg) ? 13'h0001 : dgap_reg + 13'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rx_on_cmd: assert property (
    cmd[`CMD_RX_ON] && !cmd[`CMD_RX_OFF] && !sw |=> rx_en_reg ##1 rx_enabled)
    else $error("receiver not enabled by on command");
  chk_rx_off_defer: assert property (
    cmd[`CMD_RX_OFF] && !sw && rx_busy && !rx_word_end |=> rx_enabled && rx_offp_reg)
    else $error("receiver disabled mid word");
  chk_rx_off_done: assert property (
    rx_offp_reg && rx_busy && rx_word_end && !cmd[`CMD_RX_ON] |=> !rx_enabled)
    else $error("receiver still enabled after word end");
  chk_tx_on_cmd: assert property (
    cmd[`CMD_TX_ON] && !cmd[`CMD_TX_OFF] && !sw |=> tx_enabled)
    else $error("transmitter not enabled by on command");
  chk_tx_off_wait: assert property (
    tx_offp_reg && tx_word_busy && cmd == 32'h0000_0000 |=> tx_enabled)
    else $error("transmitter disabled mid word");
  chk_soft_reset: assert property (
    sw |=> !rx_enabled && !tx_enabled && state_reg == RX_IDLE && soft_reset_pulse)
    else $error("soft reset did not win");
  chk_div_idle: assert property (
    (div_n == 12'h000) [*2] |-> !div_clock)
    else $error("divided clock runs with zero divider");
  chk_div_rate: assert property (
    dseen_reg && div_clk_reg != dprev_reg && div_n != 12'h000 |-> dgap_reg == {1'b0, div_n})
    else $error("divided clock half period wrong");
  chk_pin_input: assert property (
    rxclk_reg[`DRV_F] != `DRV_CONT && rxclk_reg[`DRV_F] != `DRV_XFER ##1
    $stable(rxclk_reg) |-> !rx_clock_oe)
    else $error("receive clock pin driven in input mode");
  chk_lag_zero: assert property (
    start_evt && lag == 8'h00 && !sw |=> rx_busy && rx_first_bit)
    else $error("zero lag did not start at once");
  chk_lag_wait: assert property (
    start_evt && lag != 8'h00 && !sw |=> state_reg == RX_LAG && !rx_first_bit)
    else $error("nonzero lag skipped");

  cov_first_bit: cover property (rx_first_bit);
  cov_cmp0_start: cover property (start_evt && st_code == `ST_CMP0);
  cov_rx_off_defer: cover property (rx_offp_reg ##[1:50] !rx_enabled);
  cov_period: cover property (rx_period_tick);
endmodule // sync_serial_ctrl_rx_clocking

// ===== logic/sync_serial_regs.svh
// register offsets, field slices, codes and reset values of the serial controller
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH
`define OFS_CMD    8'h00
`define OFS_RATE   8'h04
`define OFS_RXCLK  8'h10
`define OFS_STAT   8'h50
`define CMD_RX_ON  0
`define CMD_RX_OFF 1
`define CMD_TX_ON  8
`define CMD_TX_OFF 9
`define CMD_SOFT_RESET_CMD  15
`define RATE_RST   32'h0000_0000
`define RATE_WMASK 32'h0000_0FFF
`define RXCLK_RST  32'h0000_0000
`define RXCLK_WMASK 32'hFFFF_1FFF
`define DIV_F      11:0
`define SRC_F      1:0
`define DRV_F      4:2
`define POL_B      5
`define GATE_F     7:6
`define START_F    11:8
`define STOP_B     12
`define LAG_F      23:16
`define PER_F      31:24
`define SRC_DIV    2'h0
`define SRC_TX     2'h1
`define SRC_PIN    2'h2
`define DRV_CONT   3'h1
`define DRV_XFER   3'h2
`define GATE_NONE  2'h0
`define GATE_LOW   2'h1
`define GATE_HIGH  2'h2
`define ST_CONT    4'h0
`define ST_TX      4'h1
`define ST_LOW     4'h2
`define ST_HIGH    4'h3
`define ST_FALL    4'h4
`define ST_RISE    4'h5
`define ST_CHG     4'h6
`define ST_EDGE    4'h7
`define ST_CMP0    4'h8
`define STAT_RECEIVER_ON_CMD  0
`define STAT_TRANSMITTER_ON_CMD  1
`define STAT_BUSY  2
`define STAT_CONT  3
`endif

// ===== logic/sync_serial_pkg.sv
// shared types of the serial controller
package sync_serial_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_LAG  = 3'b010,
    RX_RECV = 3'b100
  } rx_state_t;
endpackage

// ===== bench/serial_peer.sv
// far-side serial peer: receive clock pin and frame sync pin levels
`timescale 1ns/1ps
module serial_peer (
  input  wire logic aclk,     // master clock
  input  wire logic run,      // frame in progress
  input  wire logic fs_level, // frame sync level to present
  output logic      pin_clk,  // receive clock pin level
  output logic      fs        // frame sync pin level
);
  logic ph = 1'b0;
  logic clk_q = 1'b0;
  // clock toggles every two master cycles within frames, stands still between
  always @(posedge aclk) begin
    if (run) begin
      ph <= ~ph;
      if (ph) clk_q <= ~clk_q;
    end
  end
  assign pin_clk = clk_q;
  assign fs = fs_level;
endmodule // serial_peer

// ===== bench/testbench.sv
// register-level testbench of the serial control and receive clock block
`timescale 1ns/1ps
module testbench;
  import sync_serial_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, fsl = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_word_busy = 1'b0;
  logic tx_start_evt = 1'b0, cmp0_match = 1'b0, cmp1_match = 1'b0, rx_word_end = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  axi_resp_t s_axi_bresp, s_axi_rresp;
  logic tx_clock_in = 1'b0, rx_clock_in, rx_clock_out, rx_clock_oe, rx_frame_sync_in;
  logic div_clock, rx_sample_tick, rx_fs_drive_tick, rx_first_bit, rx_busy;
  logic rx_period_tick, rx_enabled, tx_enabled, soft_reset_pulse;
  int err_count = 0, n_tests = 0, t;
  always #5 aclk = ~aclk;
  serial_peer peer (.aclk, .run, .fs_level(fsl), .pin_clk(rx_clock_in), .fs(rx_frame_sync_in));
  sync_serial_ctrl_rx_clocking dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_clock_in, .rx_clock_in, .rx_clock_out,
    .rx_clock_oe, .rx_frame_sync_in, .tx_start_evt, .tx_word_busy, .cmp0_match,
    .cmp1_match, .rx_word_end, .div_clock, .rx_sample_tick, .rx_fs_drive_tick,
    .rx_first_bit, .rx_busy, .rx_period_tick, .rx_enabled, .tx_enabled, .soft_reset_pulse);
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // write with address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin ah = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin wh = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, 2'h0);
    s_axi_bready <= 1'b0;
  endtask
  // read one word and its response code
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // read and compare data and response
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  // level changes of divided clock (0) or pin drive (1), or period pulses (2), over n cycles
  task tog(input int s, input int n);
    logic p;
    t = 0;
    #1;
    p = (s == 1) ? rx_clock_out : div_clock;
    repeat (n) begin
      @(posedge aclk);
      #1;
      if (s == 2) t += (rx_period_tick === 1'b1);
      else if (((s == 1) ? rx_clock_out : div_clock) !== p) t++;
      p = (s == 1) ? rx_clock_out : div_clock;
    end
  endtask
  task settle(input int n = 3);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // one-cycle strobe: 0 word end, 1 transmitter start, 2 compare 0, 3 compare 1
  task pulse(input int s);
    @(posedge aclk);
    {cmp1_match, cmp0_match, tx_start_evt, rx_word_end} <= 4'h1 << s;
    @(posedge aclk);
    {cmp1_match, cmp0_match, tx_start_evt, rx_word_end} <= 4'h0;
  endtask
  // sampling ticks seen up to and including the first bit pulse
  task lag_ticks(input int e);
    t = 0;
    repeat (60) begin
      @(posedge aclk);
      #1;
      if (rx_sample_tick === 1'b1) t++;
      if (rx_first_bit === 1'b1) break;
    end
    chk(rx_first_bit, 1'b1);
    chk(t, e);
  endtask
  task complete_run;
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h04, 32'h0, 2'h0);
    rdc(8'h10, 32'h0, 2'h0);
    rdc(8'h00, 32'h0, 2'h0);
    rdc(8'h08, 32'h0, 2'h2);
    tog(1'b0, 60); chk(t, 0);
    wr(8'h04, 32'h3); rdc(8'h04, 32'h3, 2'h0);
    tog(1'b0, 60); chk(t, 20);
    wr(8'h00, 32'h3); settle; chk(rx_enabled, 1'b0);
    wr(8'h00, 32'h1); settle; chk(rx_enabled, 1'b1);
    wr(8'h00, 32'h0); settle; chk(rx_enabled, 1'b1);
    chk(rx_busy, 1'b1);
    wr(8'h00, 32'h2); settle; chk(rx_enabled, 1'b1);
    pulse(0); settle; chk(rx_enabled, 1'b0);
    wr(8'h00, 32'h1);
    tx_word_busy <= 1'b1;
    wr(8'h00, 32'h100); settle; chk(tx_enabled, 1'b1);
    wr(8'h00, 32'h200); settle; chk(tx_enabled, 1'b1);
    tx_word_busy <= 1'b0; settle; chk(tx_enabled, 1'b0);
    wr(8'h00, 32'h100);
    wr(8'h10, 32'h26); rdc(8'h10, 32'h26, 2'h0);
    run <= 1'b1; settle; chk(rx_clock_oe, 1'b1);
    tog(1'b1, 40); chk(t, 20);
    wr(8'h10, 32'hA6); settle; tog(1'b1, 40); chk(t, 0);
    wr(8'h10, 32'h22); settle; chk(rx_clock_oe, 1'b0);
    wr(8'h10, 32'h0002_0500); pulse(0); settle; chk(rx_busy, 1'b0);
    fsl <= 1'b1; lag_ticks(3);
    wr(8'h10, 32'h0002_0100); pulse(0); pulse(1); lag_ticks(3);
    wr(8'h10, 32'h0000_0800); pulse(0); pulse(2); lag_ticks(1);
    pulse(0); settle(20); chk(rx_busy, 1'b0);
    wr(8'h10, 32'h0000_1800); pulse(2); lag_ticks(1);
    pulse(0); settle(20); chk(rx_busy, 1'b1);
    pulse(3); pulse(0); settle(20); chk(rx_busy, 1'b0);
    wr(8'h10, 32'h0100_0000); settle(30); tog(2, 96); chk(t, 4);
    wr(8'h00, 32'h8101); settle; chk({rx_enabled, tx_enabled}, 2'b00);
    chk(rx_busy, 1'b0);
    rdc(8'h04, 32'h0, 2'h0);
    rdc(8'h10, 32'h0, 2'h0);
    rdc(8'h50, 32'h0, 2'h0);
    complete_run;
  end
endmodule // testbench
